// *** core/csp_port.sv ***
// cache data ram port: drives asynchronous static rams holding cache lines

// What this block does
// - drives cache rams directly, no glue
// - size 0K/16K/32K/64K, one/two/four ways
// - configuration comes from software inputs only
// - word address on bits 15 to 1
// - address bit two also shared out
// - sixteen bit data bus to rams
// - byte selects active low during accesses
// - write strobe low pulse in writes only
// - read strobe low pulse in reads only
// - byte write enables one select only
// - modes are read, write and idle
// - read drives address, selects, read strobe
// - address and selects lead read strobe
// - selects stay low for back-to-back access
// - write drives address, selects, data, strobe
// - idle holds pins steady, strobes inactive
// - every access lasts two clocks
module csp_port (
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        clk_en,
    input  wire logic [1:0]                  cfg_size,
    input  wire logic [1:0]                  cfg_ways,
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire logic                        req_write,
    input  wire logic [csp_pkg::ADDR_W-1:0]  req_word,
    input  wire logic [1:0]                  req_way,
    input  wire logic [csp_pkg::LANE_W-1:0]  req_byte_en,
    input  wire logic [csp_pkg::DATA_W-1:0]  req_wdata,
    output logic                             rsp_valid,
    output logic [csp_pkg::DATA_W-1:0]       rsp_data,
    output logic [csp_pkg::ADDR_W:1]         cache_word_addr,
    output logic                             addr_bit_two_shared,
    output logic                             high_byte_select_n,
    output logic                             low_byte_select_n,
    output logic                             write_strobe_n,
    output logic                             read_strobe_n,
    output logic [csp_pkg::DATA_W-1:0]       cache_data_out,
    output logic                             cache_data_oe,
    input  wire logic [csp_pkg::DATA_W-1:0]  cache_data_in
);

    // places the way number above the index that fits one way
    function automatic logic [csp_pkg::ADDR_W-1:0] map_word(
        input logic [1:0]                 size,
        input logic [1:0]                 ways,
        input logic [1:0]                 way,
        input logic [csp_pkg::ADDR_W-1:0] word
    );
        int                        way_bits;
        int                        shift;
        logic [csp_pkg::ADDR_W-1:0] mask;
        logic [csp_pkg::ADDR_W-1:0] way_part;
        way_bits = (ways == csp_pkg::WAYS_DIRECT) ? 0 : (ways == csp_pkg::WAYS_TWO) ? 1 : 2;
        shift    = csp_pkg::WORD_BITS_BASE + int'(size) - way_bits;
        mask     = csp_pkg::ADDR_W'((32'd1 << shift) - 32'd1);
        way_part = csp_pkg::ADDR_W'(32'(way & 2'(((32'd1 << way_bits) - 32'd1))) << shift);
        return way_part | (word & mask);
    endfunction

    csp_seq_if seq_bus ();

    csp_seq u_seq (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .bus     (seq_bus)
    );

    logic                        cur_write;
    logic [csp_pkg::DATA_W-1:0]  data_sync1;
    logic [csp_pkg::DATA_W-1:0]  data_sync2;
    logic                        rd_pend1;
    logic                        rd_pend2;

    wire in_idle     = seq_bus.phase == csp_pkg::CSP_IDLE;
    wire in_setup    = seq_bus.phase == csp_pkg::CSP_SETUP;
    wire in_strobe   = seq_bus.phase == csp_pkg::CSP_STROBE;
    // a zero sized cache takes no accesses
    wire cache_on    = cfg_size != csp_pkg::SIZE_0K;
    // a new request is taken in idle or in the last clock of an access
    wire take        = req_valid && req_ready;
    // address layout follows the configuration inputs
    wire [csp_pkg::ADDR_W-1:0] mapped = map_word(cfg_size, cfg_ways, req_way, req_word);
    wire strobe_end  = in_strobe && !take;

    assign req_ready    = cache_on && (in_idle || in_strobe);
    assign seq_bus.take = take;
    // bit two also feeds the coprocessor
    assign addr_bit_two_shared = cache_word_addr[2];

    // address changes only when an access is taken
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cache_word_addr <= csp_pkg::ADDR_RST;
            cur_write       <= 1'b0;
        end else if (clk_en && take) begin
            cache_word_addr <= mapped;
            cur_write       <= req_write;
        end
    end

    // only the enabled lanes are selected
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            {high_byte_select_n, low_byte_select_n} <= csp_pkg::SEL_RST;
        end else if (clk_en) begin
            if (take) begin
                {high_byte_select_n, low_byte_select_n} <= ~req_byte_en;
            end else if (strobe_end) begin
                {high_byte_select_n, low_byte_select_n} <= csp_pkg::SEL_RST;
            end
        end
    end

    // strobes fall one clock after address and selects
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            write_strobe_n <= 1'b1;
            read_strobe_n  <= 1'b1;
        end else if (clk_en) begin
            write_strobe_n <= !(in_setup && cur_write);
            read_strobe_n  <= !(in_setup && !cur_write);
        end
    end

    // write data driven from setup to the end of the strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cache_data_out <= csp_pkg::DATA_RST;
            cache_data_oe  <= 1'b0;
        end else if (clk_en) begin
            if (take) begin
                cache_data_oe <= req_write;
                if (req_write) begin
                    cache_data_out <= req_wdata;
                end
            end else if (strobe_end) begin
                cache_data_oe <= 1'b0;
            end
        end
    end

    // read data from the rams passes two flip-flops
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            data_sync1 <= csp_pkg::DATA_RST;
            data_sync2 <= csp_pkg::DATA_RST;
        end else if (clk_en) begin
            data_sync1 <= cache_data_in;
            data_sync2 <= data_sync1;
        end
    end

    // read response follows the synchroniser delay
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_pend1  <= 1'b0;
            rd_pend2  <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data  <= csp_pkg::DATA_RST;
        end else if (clk_en) begin
            rd_pend1  <= in_strobe && !cur_write;
            rd_pend2  <= rd_pend1;
            rsp_valid <= rd_pend2;
            if (rd_pend2) begin
                rsp_data <= data_sync2;
            end
        end
    end

    property p_lead_read;
        @(posedge sys_clk) disable iff (sys_rst || !clk_en)
        $fell(read_strobe_n) |-> $stable(cache_word_addr)
            && $past(!high_byte_select_n || !low_byte_select_n);
    endproperty
    a_lead_read: assert property (p_lead_read) else $error("read strobe before select");

    property p_write_only;
        @(posedge sys_clk) disable iff (sys_rst)
        !write_strobe_n |-> cache_data_oe && cur_write && read_strobe_n;
    endproperty
    a_write_only: assert property (p_write_only) else $error("write strobe outside write");

    property p_read_released;
        @(posedge sys_clk) disable iff (sys_rst)
        !read_strobe_n |-> !cache_data_oe && !cur_write && write_strobe_n;
    endproperty
    a_read_released: assert property (p_read_released) else $error("bus driven in read");

    property p_drive_write;
        @(posedge sys_clk) disable iff (sys_rst)
        cache_data_oe |-> cur_write && !in_idle;
    endproperty
    a_drive_write: assert property (p_drive_write) else $error("data driven outside write");

    property p_idle_quiet;
        @(posedge sys_clk) disable iff (sys_rst || !clk_en)
        in_idle && $past(in_idle) |-> read_strobe_n && write_strobe_n && !cache_data_oe
            && high_byte_select_n && low_byte_select_n && $stable(cache_word_addr);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle pins not steady");

    property p_select_lanes;
        @(posedge sys_clk) disable iff (sys_rst || !clk_en)
        take |=> {high_byte_select_n, low_byte_select_n} == ~$past(req_byte_en)
            && cache_word_addr == $past(mapped);
    endproperty
    a_select_lanes: assert property (p_select_lanes) else $error("wrong selects");

    property p_back_to_back;
        @(posedge sys_clk) disable iff (sys_rst || !clk_en)
        in_strobe && take && (req_byte_en != 2'h0)
            |=> !high_byte_select_n || !low_byte_select_n;
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("selects dropped");

    property p_read_timing;
        @(posedge sys_clk) disable iff (sys_rst || !clk_en)
        take && !req_write |=> read_strobe_n ##1 !read_strobe_n ##1 read_strobe_n
            ##2 rsp_valid;
    endproperty
    a_read_timing: assert property (p_read_timing) else $error("read sequence wrong");

    property p_write_timing;
        @(posedge sys_clk) disable iff (sys_rst || !clk_en)
        take && req_write |=> cache_data_oe && write_strobe_n
            ##1 !write_strobe_n && cache_data_oe && cache_data_out == $past(req_wdata, 2);
    endproperty
    a_write_timing: assert property (p_write_timing) else $error("write sequence wrong");

endmodule // csp_port

// *** core/csp_pkg.sv ***
// shared constants and types of the cache data ram port
package csp_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;
    localparam int LANE_W = 2;

    // cache size selection codes
    localparam logic [1:0] SIZE_0K  = 2'h0;
    localparam logic [1:0] SIZE_16K = 2'h1;
    localparam logic [1:0] SIZE_32K = 2'h2;
    localparam logic [1:0] SIZE_64K = 2'h3;

    // organisation codes; the unused code behaves as four-way
    localparam logic [1:0] WAYS_DIRECT = 2'h0;
    localparam logic [1:0] WAYS_TWO    = 2'h1;
    localparam logic [1:0] WAYS_FOUR   = 2'h2;

    // word index bits of the smallest cache, one less than its size code adds
    localparam int WORD_BITS_BASE = 12;
    // processor clocks per memory access
    localparam int ACCESS_CLKS = 2;
    // cycles from the end of the strobe phase to the response
    localparam int RSP_DELAY = 2;

    // reset values of the pins
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [LANE_W-1:0] SEL_RST  = 2'h3;

    typedef enum logic [1:0] {
        CSP_IDLE   = 2'b00,
        CSP_SETUP  = 2'b01,
        CSP_STROBE = 2'b10
    } csp_phase_e;

endpackage : csp_pkg

// *** core/csp_seq_if.sv ***
// carrier between the pin controller and the access sequencer
interface csp_seq_if;
    logic                take;
    csp_pkg::csp_phase_e phase;

    modport ctrl (output take, input phase);
    modport seq  (input take, output phase);
endinterface : csp_seq_if

// *** core/csp_seq.sv ***
// two-clock access sequencer of the cache data ram port
module csp_seq (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    csp_seq_if.seq    bus
);

    csp_pkg::csp_phase_e next_phase;

    always_comb begin
        case (bus.phase)
            csp_pkg::CSP_IDLE:   next_phase = bus.take ? csp_pkg::CSP_SETUP : csp_pkg::CSP_IDLE;
            csp_pkg::CSP_SETUP:  next_phase = csp_pkg::CSP_STROBE;
            csp_pkg::CSP_STROBE: next_phase = bus.take ? csp_pkg::CSP_SETUP : csp_pkg::CSP_IDLE;
            default:             next_phase = csp_pkg::CSP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bus.phase <= csp_pkg::CSP_IDLE;
        end else if (clk_en) begin
            bus.phase <= next_phase;
        end
    end

    property p_two_clocks;
        @(posedge sys_clk) disable iff (sys_rst || !clk_en)
        bus.take |=> bus.phase == csp_pkg::CSP_SETUP ##1 bus.phase == csp_pkg::CSP_STROBE;
    endproperty
    a_two_clocks: assert property (p_two_clocks) else $error("access not two clocks");

    property p_three_modes;
        @(posedge sys_clk) disable iff (sys_rst || !clk_en)
        bus.phase == csp_pkg::CSP_STROBE && !bus.take |=> bus.phase == csp_pkg::CSP_IDLE;
    endproperty
    a_three_modes: assert property (p_three_modes) else $error("no return to idle");

endmodule // csp_seq

// *** tb/csp_sram_model.sv ***
// behavioural asynchronous static ram array seen from the cache port
module csp_sram_model (
    input  wire logic                        sys_clk,
    input  wire logic [csp_pkg::ADDR_W:1]    cache_word_addr,
    input  wire logic                        high_byte_select_n,
    input  wire logic                        low_byte_select_n,
    input  wire logic                        write_strobe_n,
    input  wire logic                        read_strobe_n,
    input  wire logic [csp_pkg::DATA_W-1:0]  cache_data_out,
    output logic      [csp_pkg::DATA_W-1:0]  cache_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:32767];
    logic [15:0] last = 16'h0000;
    logic        hi_drv;
    logic        lo_drv;
    assign hi_drv = !high_byte_select_n && !read_strobe_n;
    assign lo_drv = !low_byte_select_n && !read_strobe_n;
    // released lanes show a changing pattern, never a held value
    assign cache_data_in = {hi_drv ? mem[cache_word_addr][15:8] : ~last[15:8],
                            lo_drv ? mem[cache_word_addr][7:0] : ~last[7:0]};
    always @(posedge sys_clk) begin
        last <= cache_data_in;
    end
    always @(negedge write_strobe_n) begin
        if (!high_byte_select_n) mem[cache_word_addr][15:8] = cache_data_out[15:8];
        if (!low_byte_select_n) mem[cache_word_addr][7:0] = cache_data_out[7:0];
    end
endmodule // csp_sram_model

// *** tb/cache_data_sram_port_bench.sv ***
// self-checking bench of the cache data ram port with a ram array model
module cache_data_sram_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, sys_rst, clk_en, req_valid, req_ready, req_write, rsp_valid;
    logic [1:0]  cfg_size, cfg_ways, req_way, req_byte_en;
    logic [14:0] req_word;
    logic [15:0] req_wdata, rsp_data, cache_data_out, cache_data_in;
    logic [15:1] cache_word_addr;
    logic        addr_bit_two_shared, high_byte_select_n, low_byte_select_n;
    logic        write_strobe_n, read_strobe_n, cache_data_oe;
    int          errors = 0;
    int          n_checks = 0;
    int          cycles = 0;

    csp_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .cfg_size(cfg_size), .cfg_ways(cfg_ways), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_word(req_word),
        .req_way(req_way), .req_byte_en(req_byte_en), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cache_word_addr(cache_word_addr),
        .addr_bit_two_shared(addr_bit_two_shared), .high_byte_select_n(high_byte_select_n),
        .low_byte_select_n(low_byte_select_n), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .cache_data_out(cache_data_out),
        .cache_data_oe(cache_data_oe), .cache_data_in(cache_data_in));
    csp_sram_model ram (.sys_clk(sys_clk), .cache_word_addr(cache_word_addr),
        .high_byte_select_n(high_byte_select_n), .low_byte_select_n(low_byte_select_n),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .cache_data_out(cache_data_out), .cache_data_in(cache_data_in));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask

    // one access, pins judged in every clock of it
    task automatic op(input logic wr, input logic [14:0] word, input logic [1:0] be,
                      input logic [15:0] wd, input logic [15:0] ea, input logic [15:0] rd);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_write = wr;
        req_word = word;
        req_way = 2'h3;
        req_byte_en = be;
        req_wdata = wd;
        while (req_ready !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        step();
        req_valid = 1'b0;
        chk("addr", ea, {1'b0, cache_word_addr});
        chk("shared", ea[1], addr_bit_two_shared);
        chk("sel1", {14'h0, ~be}, {14'h0, high_byte_select_n, low_byte_select_n});
        chk("strb1", 16'h3, {14'h0, write_strobe_n, read_strobe_n});
        chk("oe1", wr, cache_data_oe);
        if (wr) chk("wdata", wd, cache_data_out);
        step();
        chk("strb2", {14'h0, !wr, wr}, {14'h0, write_strobe_n, read_strobe_n});
        chk("sel2", {14'h0, ~be}, {14'h0, high_byte_select_n, low_byte_select_n});
        chk("oe2", wr, cache_data_oe);
        step();
        chk("strb3", 16'h3, {14'h0, write_strobe_n, read_strobe_n});
        chk("sel3", 16'h3, {14'h0, high_byte_select_n, low_byte_select_n});
        chk("oe3", 16'h0, cache_data_oe);
        if (!wr) begin
            step();
            chk("rsp_early", 16'h0, rsp_valid);
            step();
            chk("rsp_valid", 16'h1, rsp_valid);
            chk("rsp_data", rd, rsp_data);
        end
    endtask

    task automatic t_b2b();
        req_valid = 1'b1;
        req_write = 1'b0;
        req_byte_en = 2'h3;
        step();
        step();
        chk("ready_strobe", 16'h1, req_ready);
        step();
        req_valid = 1'b0;
        chk("sel_keep", 16'h0, {14'h0, high_byte_select_n, low_byte_select_n});
        chk("strb_gap", 16'h1, read_strobe_n);
        step();
        chk("strb_two", 16'h0, read_strobe_n);
        step();
        chk("rsp_one", 16'h3CC3, rsp_valid ? rsp_data : 16'hXXXX);
        step();
        chk("rsp_pulse", 16'h0, rsp_valid);
        step();
        chk("rsp_two", 16'h3CC3, rsp_valid ? rsp_data : 16'hXXXX);
    endtask

    task automatic t_zero();
        logic [15:1] held;
        held = cache_word_addr;
        cfg_size = csp_pkg::SIZE_0K;
        req_valid = 1'b1;
        repeat (4) begin
            step();
            chk("ready_zero", 16'h0, req_ready);
            chk("idle_sel", 16'h3, {14'h0, high_byte_select_n, low_byte_select_n});
            chk("idle_addr", {1'b0, held}, {1'b0, cache_word_addr});
        end
        req_valid = 1'b0;
        cfg_size = csp_pkg::SIZE_64K;
    endtask

    // clock enable low freezes a write in its setup clock
    task automatic t_hold();
        req_valid = 1'b1;
        req_write = 1'b1;
        req_word = 15'h0456;
        req_byte_en = 2'h3;
        req_wdata = 16'h5AA5;
        step();
        req_valid = 1'b0;
        clk_en = 1'b0;
        repeat (3) begin
            step();
            chk("hold_strb", 16'h3, {14'h0, write_strobe_n, read_strobe_n});
            chk("hold_sel", 16'h0, {14'h0, high_byte_select_n, low_byte_select_n});
            chk("hold_oe", 16'h1, cache_data_oe);
        end
        clk_en = 1'b1;
        step();
        chk("hold_go", 16'h1, {14'h0, write_strobe_n, read_strobe_n});
        step();
        chk("hold_end", 16'h3, {14'h0, high_byte_select_n, low_byte_select_n});
        op(1'b0, 15'h0456, 2'h3, 16'h0000, 16'h0456, 16'h5AA5);
    endtask

    task automatic t_map();
        int wb;
        int ib;
        for (int s = 1; s < 4; s++) begin
            for (int w = 0; w < 4; w++) begin
                wb = (w == 3) ? 2 : w;
                ib = 12 + s - wb;
                cfg_size = 2'(s);
                cfg_ways = 2'(w);
                op(1'b1, 15'h7FFF, 2'h0, 16'hFFFF,
                   16'((32'h7FFF & ((1 << ib) - 1)) | ((3 & ((1 << wb) - 1)) << ib)),
                   16'h0);
            end
        end
        cfg_size = csp_pkg::SIZE_64K;
        cfg_ways = csp_pkg::WAYS_DIRECT;
    endtask

    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        cfg_size = csp_pkg::SIZE_64K;
        cfg_ways = csp_pkg::WAYS_DIRECT;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_word = 15'h1234;
        req_way = 2'h0;
        req_byte_en = 2'h0;
        req_wdata = 16'h0000;
        repeat (12) step();
        chk("rst_pins", 16'h3F, {10'h0, high_byte_select_n, low_byte_select_n,
            write_strobe_n, read_strobe_n, cache_data_oe, rsp_valid} ^ 16'h3);
        chk("rst_addr", 16'h0, {1'b0, cache_word_addr});
        sys_rst = 1'b0;
        op(1'b1, 15'h1234, 2'h3, 16'hA55A, 16'h1234, 16'h0);
        op(1'b0, 15'h1234, 2'h3, 16'h0000, 16'h1234, 16'hA55A);
        op(1'b1, 15'h1234, 2'h1, 16'h00C3, 16'h1234, 16'h0);
        op(1'b1, 15'h1234, 2'h2, 16'h3C00, 16'h1234, 16'h0);
        op(1'b0, 15'h1234, 2'h3, 16'h0000, 16'h1234, 16'h3CC3);
        t_b2b();
        t_zero();
        t_hold();
        t_map();
        end_sim();
    end
endmodule // cache_data_sram_port_bench
